//--- core/arb_defs.svh
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// Register offsets on the configuration port; the status word sits at a free offset.
`define ARB_OFF_RSVD    8'h44
`define ARB_OFF_CTRL    8'h48
`define ARB_OFF_STAT    8'h80

// Reset value and writable-bit mask of the arbitration control word.
`define ARB_CTRL_RESET  32'h0040_801F
`define ARB_CTRL_WMASK  32'h07DF_FE1F

// Field positions inside the arbitration control word.
`define ARB_EN_LSB      0
`define ARB_EXT_BIT     9
`define ARB_BM_EN_BIT   10
`define ARB_BM_REF_BIT  11
`define ARB_FAIR_LSB    12
`define ARB_TOG_BIT     20
`define ARB_PRIO_LSB    22

// Idle bus cycles a granted master may waste before it is called broken.
`define ARB_BM_CYCLES   5'h10

`endif

//--- core/arb_pkg.sv
`default_nettype none

package arb_pkg;

    // One access from the register port.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    // Sampled secondary bus signals, all active low.
    typedef struct packed {
        logic [4:0] req_n;
        logic       frame_n;
        logic       irdy_n;
    } pci_in_s;

    typedef enum logic {
        ST_IDLE,
        ST_GRANT
    } arb_state_e;

    typedef logic [2:0] req_idx_t;

    // Turns a requester index into a one-hot vector.
    function automatic logic [4:0] onehot5(input req_idx_t idx);
        onehot5 = 5'h01 << idx;
    endfunction : onehot5

endpackage : arb_pkg

`default_nettype wire

//--- core/arb_pick.sv
`default_nettype none

module arb_pick (
    input  wire logic [4:0]        pool,
    input  wire arb_pkg::req_idx_t last,
    output logic                   valid,
    output arb_pkg::req_idx_t      idx
);
    import arb_pkg::*;

    // Walks the ring starting just after the last winner and takes the first candidate.
    always_comb begin
        req_idx_t cand;
        cand = last;
        valid = 1'b0;
        idx = last;
        for (int k = 0; k < 5; k++) begin
            cand = (cand == 3'h4) ? 3'h0 : req_idx_t'(cand + 3'h1);
            if (!valid && pool[cand]) begin
                valid = 1'b1;
                idx = cand;
            end
        end
    end

endmodule : arb_pick

`default_nettype wire

//--- core/pci_secondary_bus_arbiter.sv
// The strobed register port was left to the implementer.
`include "arb_defs.svh"
`default_nettype none

module pci_secondary_bus_arbiter (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire arb_pkg::reg_req_s reg_req,
    output logic [31:0]            reg_rdata,
    input  wire arb_pkg::pci_in_s  pci_in,
    output logic [4:0]             gnt_n,
    output logic                   ext_arb_sel
);
    import arb_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] rdata_q;
    arb_state_e  state_q;
    arb_state_e  state_d;
    req_idx_t    own_q;
    req_idx_t    own_d;
    req_idx_t    last_q;
    logic [4:0]  gnt_n_q;
    logic [4:0]  gnt_n_d;
    logic [7:0]  fair_q;
    logic [7:0]  fair_d;
    logic [4:0]  bm_q;
    logic [4:0]  bm_d;
    logic        armed_q;
    logic        started_q;
    logic        frame_prev_q;
    logic        fall_d1_q;
    logic [4:0]  broken_q;
    logic [4:0]  served_q;
    logic        issue_w;
    logic        drop_w;

    // Control fields decoded from the control word.
    wire logic [4:0] en_w       = ctrl_q[`ARB_EN_LSB +: 5];
    wire logic       ext_w      = ctrl_q[`ARB_EXT_BIT];
    wire logic       bm_en_w    = ctrl_q[`ARB_BM_EN_BIT];
    wire logic       bm_ref_w   = ctrl_q[`ARB_BM_REF_BIT];
    wire logic [7:0] fair_fld_w = ctrl_q[`ARB_FAIR_LSB +: 8];
    wire logic       tog_en_w   = ctrl_q[`ARB_TOG_BIT];
    wire logic [4:0] prio_w     = ctrl_q[`ARB_PRIO_LSB +: 5];

    // Register port decode.
    wire logic wr_ctrl_w = reg_req.wr && (reg_req.addr == `ARB_OFF_CTRL);
    wire logic rd_ctrl_w = reg_req.rd && (reg_req.addr == `ARB_OFF_CTRL);
    wire logic rd_stat_w = reg_req.rd && (reg_req.addr == `ARB_OFF_STAT);
    wire logic [31:0] stat_w = {11'h000, fair_q, last_q, broken_q, ~gnt_n_q};

    // Bus observations.
    wire logic       busy_w    = (state_q == ST_GRANT);
    wire logic       idle_w    = pci_in.frame_n && pci_in.irdy_n;
    wire logic       fall_w    = frame_prev_q && !pci_in.frame_n;
    wire logic [4:0] own_oh_w  = onehot5(own_q);
    wire logic       own_req_w = !pci_in.req_n[own_q];

    // Requesters that may win: enabled, asking, not broken, internal arbiter active.
    wire logic [4:0] elig_w   = ~pci_in.req_n & en_w & ~broken_q & {5{!ext_w}};
    wire logic [4:0] hi_w     = elig_w & prio_w;
    wire logic [4:0] pool_w   = (|hi_w) ? hi_w : elig_w;
    wire logic       others_w = |(elig_w & ~own_oh_w);

    // Broken-master watchdog: the sixteenth idle cycle without FRAME ends the grant.
    wire logic bm_hit_w = busy_w && bm_en_w && !started_q && idle_w
                          && (bm_q == (`ARB_BM_CYCLES - 5'h01));

    // Fairness expiry only matters while another requester waits.
    wire logic fair_drop_w = busy_w && armed_q && (fair_fld_w != 8'h00)
                             && (fair_q == 8'h00) && others_w;

    // Toggle pulse: frame fell two cycles before the cycle in which GNT shows high.
    wire logic tog_w = tog_en_w && fall_d1_q && busy_w;

    logic     pick_valid;
    req_idx_t pick_idx;

    arb_pick u_pick (
        .pool  (pool_w),
        .last  (last_q),
        .valid (pick_valid),
        .idx   (pick_idx)
    );

    // Grant state machine: issues a grant from idle and decides when it ends.
    always_comb begin
        state_d = state_q;
        own_d = own_q;
        issue_w = 1'b0;
        drop_w = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (pick_valid) begin
                    issue_w = 1'b1;
                    state_d = ST_GRANT;
                    own_d = pick_idx;
                end
            end
            ST_GRANT: begin
                if (ext_w || bm_hit_w || !own_req_w || !en_w[own_q] || fair_drop_w) begin
                    drop_w = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Grant outputs, active low, with the optional one-clock toggle.
    assign gnt_n_d = (state_d == ST_GRANT) ? (~onehot5(own_d) | {5{tog_w && !drop_w}}) : 5'h1F;

    // Fairness counter: reload on grant, count down once armed and contended.
    always_comb begin
        fair_d = fair_q;
        if (issue_w) begin
            fair_d = fair_fld_w;
        end else if (busy_w && armed_q && others_w && (fair_q != 8'h00)) begin
            fair_d = fair_q - 8'h01;
        end
    end

    // Watchdog counter runs only while the granted master leaves the bus idle.
    always_comb begin
        bm_d = bm_q;
        if (issue_w) begin
            bm_d = 5'h00;
        end else if (busy_w && bm_en_w && !started_q && idle_w) begin
            bm_d = bm_q + 5'h01;
        end
    end

    // Configuration register; only documented bits are writable.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= `ARB_CTRL_RESET;
        end else if (wr_ctrl_w) begin
            ctrl_q <= reg_req.wdata & `ARB_CTRL_WMASK;
        end
    end

    // Read data stands for the single cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd_ctrl_w ? ctrl_q : (rd_stat_w ? stat_w : 32'h0000_0000);
        end
    end

    // Grant state, owner and round-robin pointer.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            own_q <= 3'h0;
            last_q <= 3'h4;
            gnt_n_q <= 5'h1F;
        end else begin
            state_q <= state_d;
            own_q <= own_d;
            gnt_n_q <= gnt_n_d;
            if (issue_w) begin
                last_q <= pick_idx;
            end
        end
    end

    // Counters and frame tracking for the current grant.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fair_q <= 8'h00;
            bm_q <= 5'h00;
            armed_q <= 1'b0;
            started_q <= 1'b0;
            frame_prev_q <= 1'b1;
            fall_d1_q <= 1'b0;
        end else begin
            fair_q <= fair_d;
            bm_q <= bm_d;
            frame_prev_q <= pci_in.frame_n;
            fall_d1_q <= fall_w && busy_w;
            armed_q <= !issue_w && (armed_q || (busy_w && fall_w));
            started_q <= !issue_w && (started_q || (busy_w && !pci_in.frame_n));
        end
    end

    // Broken flags and the served record used to refresh them.
    generate
        for (genvar i = 0; i < 5; i++) begin : g_broken
            wire logic others_served_w = &(served_q | ~en_w | broken_q | onehot5(req_idx_t'(i)));
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    broken_q[i] <= 1'b0;
                end else if (bm_hit_w && (own_q == req_idx_t'(i))) begin
                    broken_q[i] <= 1'b1;
                end else if (bm_ref_w && others_served_w) begin
                    broken_q[i] <= 1'b0;
                end
            end
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    served_q[i] <= 1'b0;
                end else if (issue_w && (pick_idx == req_idx_t'(i))) begin
                    served_q[i] <= 1'b1;
                end else if (bm_ref_w && |(broken_q) && others_served_w && broken_q[i] == 1'b0
                             && &(served_q | ~en_w | broken_q)) begin
                    served_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign reg_rdata = rdata_q;
    assign gnt_n = gnt_n_q;
    assign ext_arb_sel = ctrl_q[`ARB_EXT_BIT];

    // Checks kept beside the logic they guard.
    AST_ISSUE_ENABLED: assert property (@(posedge clk) disable iff (!reset_n)
        issue_w |-> (en_w[pick_idx] && !pci_in.req_n[pick_idx]))
        else $error("Grant issued to a disabled or idle requester.");

    AST_EXT_NO_GNT: assert property (@(posedge clk) disable iff (!reset_n)
        ext_w |=> (gnt_n_q == 5'h1F))
        else $error("Grant driven while external arbiter is selected.");

    AST_BM_TIMEOUT: assert property (@(posedge clk) disable iff (!reset_n)
        (busy_w && bm_en_w && !started_q && idle_w && bm_q == 5'h0F) |=> (gnt_n_q == 5'h1F))
        else $error("Grant not removed on the sixteenth idle cycle.");

    AST_BM_MARK: assert property (@(posedge clk) disable iff (!reset_n)
        bm_hit_w |=> broken_q[$past(own_q)])
        else $error("Timed-out master not marked broken.");

    AST_BM_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
        (!bm_ref_w && !wr_ctrl_w) |=> ((broken_q & $past(broken_q)) == $past(broken_q)))
        else $error("Broken master cleared without refresh.");

    AST_FAIR_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
        (issue_w && !wr_ctrl_w) |=> (fair_q == $past(fair_fld_w)))
        else $error("Fairness counter not reloaded on new grant.");

    AST_FAIR_UNARMED: assert property (@(posedge clk) disable iff (!reset_n)
        (!armed_q && !issue_w) |=> (fair_q == $past(fair_q)))
        else $error("Fairness counter moved before frame fell.");

    AST_FAIR_ZERO_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (busy_w && fair_fld_w == 8'h00 && own_req_w && en_w[own_q] && !ext_w && !bm_hit_w)
        |=> (state_q == ST_GRANT) && (own_q == $past(own_q)))
        else $error("Grant removed while owner still requests with fairness zero.");

    AST_NO_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
        (!tog_en_w && busy_w && !drop_w) |=> (gnt_n_q == ~onehot5(own_q)))
        else $error("Grant toggled with toggling disabled.");

    AST_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
        (tog_en_w && busy_w && fall_w && !wr_ctrl_w) ##1 (busy_w && !drop_w)
        |=> (gnt_n_q == 5'h1F) ##1 (!busy_w || gnt_n_q == ~own_oh_w))
        else $error("Grant toggle pulse misplaced.");

    AST_HIGH_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
        (issue_w && |hi_w) |-> prio_w[pick_idx])
        else $error("Low-priority requester chosen over a high one.");

    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_req.rd && reg_req.addr == `ARB_OFF_RSVD) |=> (reg_rdata == 32'h0000_0000))
        else $error("Reserved register read non-zero.");

endmodule : pci_secondary_bus_arbiter

`default_nettype wire

//--- verif/pci_master_model.sv
`default_nettype none

module pci_master_model import arb_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  want,
    input  wire logic [4:0]  lazy,
    input  wire logic [4:0]  gnt_n,
    output arb_pkg::pci_in_s pci_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_q;
    wire        start = (phase_q == 2'h0) && |(~gnt_n & ~lazy & want);

    // A granted master that is not lazy runs a one-data-phase transfer whenever the bus is idle.
    always_ff @(posedge clk) begin
        if (!reset_n || phase_q == 2'h2) begin
            phase_q <= 2'h0;
        end else if (start || phase_q == 2'h1) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Requests follow the bench; FRAME marks the address phase, IRDY the last data phase.
    assign pci_in.req_n   = ~want;
    assign pci_in.frame_n = (phase_q != 2'h1);
    assign pci_in.irdy_n  = (phase_q != 2'h2);
endmodule : pci_master_model

`default_nettype wire

//--- verif/testbench.sv
`include "arb_defs.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import arb_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0]  want;
        logic [4:0]  gnt;
    } row_s;

    logic        clk        = 1'b0;
    logic        reset_n    = 1'b0;
    reg_req_s    reg_req    = '0;
    logic [4:0]  want       = 5'h00;
    logic [4:0]  lazy       = 5'h00;
    logic [31:0] reg_rdata;
    pci_in_s     pci_in;
    logic [4:0]  gnt_n;
    logic        ext_arb_sel;
    logic [31:0] rd;
    int          num_errors = 0;
    int          compares   = 0;
    int          n;
    row_s        rows [6]   = '{'{32'h0040801F, 5'h1F, 5'h1E}, '{32'h0040801E, 5'h1F, 5'h1D},
                                '{32'h0400801F, 5'h1F, 5'h0F}, '{32'h0040821F, 5'h1F, 5'h1F},
                                '{32'h0040801F, 5'h1C, 5'h1B}, '{32'h0040800F, 5'h10, 5'h1F}};

    // The clock toggles every half period of 12.5 ns.
    always #12.5 clk = ~clk;

    pci_secondary_bus_arbiter dut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
                                   .pci_in(pci_in), .gnt_n(gnt_n), .ext_arb_sel(ext_arb_sel));
    pci_master_model masters (.clk(clk), .reset_n(reset_n), .want(want), .lazy(lazy), .gnt_n(gnt_n),
                              .pci_in(pci_in));

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        reg_req <= '0;
        // One idle edge keeps a following request from reassigning the strobe in the same time step.
        tick(1);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        tick(1);
        reg_req <= '0;
        d = reg_rdata;
        tick(1);
    endtask : reg_read

    task automatic do_reset();
        // An edge first, so no request signal is assigned twice in one time step.
        tick(1);
        reset_n <= 1'b0;
        want    <= 5'h00;
        lazy    <= 5'h00;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
    endtask : do_reset

    // Waits a bounded time for a grant pattern; running out ends the run.
    task automatic wait_gnt(input logic [4:0] exp, input int bound);
        n = 0;
        while (gnt_n !== exp && n < bound) begin
            tick(1);
            n++;
        end
        check("grant wait", {27'h0, exp}, {27'h0, gnt_n});
        if (gnt_n !== exp) begin
            report_and_stop();
        end
    endtask : wait_gnt

    // Counts the cycles for which a grant pattern stays on the bus.
    task automatic hold_len(input logic [4:0] g, input int bound);
        n = 0;
        while (gnt_n === g && n < bound) begin
            n++;
            tick(1);
        end
    endtask : hold_len

    // Reset values, grant table, register map, then the hand-written cases.
    initial begin
        do_reset();
        reg_read(`ARB_OFF_CTRL, rd);
        check("control reset", `ARB_CTRL_RESET, rd);
        check("idle grants", 32'h1F, {27'h0, gnt_n});
        $display("test reset done");
        foreach (rows[i]) begin
            do_reset();
            reg_write(`ARB_OFF_CTRL, rows[i].ctrl);
            want <= rows[i].want;
            tick(2);
            check("row grant", {27'h0, rows[i].gnt}, {27'h0, gnt_n});
            check("row ext", {31'h0, rows[i].ctrl[9]}, {31'h0, ext_arb_sel});
        end
        $display("test grant table done");

        reg_write(`ARB_OFF_CTRL, 32'hFFFFFFFF);
        reg_write(`ARB_OFF_RSVD, 32'hFFFFFFFF);
        reg_read(`ARB_OFF_CTRL, rd);
        check("control mask", 32'h07DFFE1F, rd);
        check("rdata idle", 32'h0, reg_rdata);
        reg_read(`ARB_OFF_RSVD, rd);
        check("reserved word", 32'h0, rd);
        reg_read(8'h10, rd);
        check("unmapped", 32'h0, rd);
        $display("test registers done");

        do_reset();
        want <= 5'h1E;
        for (int k = 1; k < 5; k++) begin
            wait_gnt(5'h1F ^ (5'h01 << k), 40);
            want[k] <= 1'b0;
        end
        $display("test round robin done");

        do_reset();
        reg_write(`ARB_OFF_CTRL, 32'h00408406);
        lazy <= 5'h02;
        want <= 5'h02;
        wait_gnt(5'h1D, 10);
        hold_len(5'h1D, 40);
        check("idle grant cycles", 32'h10, n);
        want <= 5'h00;
        tick(2);
        want <= 5'h02;
        lazy <= 5'h00;
        tick(20);
        check("broken ignored", 32'h1F, {27'h0, gnt_n});
        // Status: fairness count 8, last winner 1, master 1 broken, no grant.
        reg_read(`ARB_OFF_STAT, rd);
        check("status word", 32'h0001_0440, rd);
        reg_write(`ARB_OFF_CTRL, 32'h00408C06);
        want <= 5'h06;
        wait_gnt(5'h1B, 20);
        want[2] <= 1'b0;
        wait_gnt(5'h1D, 40);
        $display("test broken master done");

        for (int t = 0; t < 2; t++) begin
            do_reset();
            reg_write(`ARB_OFF_CTRL, t ? 32'h0050801F : 32'h0040801F);
            want <= 5'h01;
            wait_gnt(5'h1E, 10);
            while (pci_in.frame_n !== 1'b0 && n < 20) begin
                tick(1);
                n++;
            end
            check("frame start", 32'h0, {31'h0, pci_in.frame_n});
            if (pci_in.frame_n !== 1'b0) begin
                report_and_stop();
            end
            // The arbiter sees FRAME low one edge later; the gap shows one clock after that.
            tick(2);
            check("toggle gap", t ? 32'h1F : 32'h1E, {27'h0, gnt_n});
            tick(1);
            check("toggle back", 32'h1E, {27'h0, gnt_n});
        end
        $display("test toggling done");

        for (int f = 0; f < 2; f++) begin
            do_reset();
            reg_write(`ARB_OFF_CTRL, f ? 32'h0040801F : 32'h0040001F);
            want <= 5'h03;
            wait_gnt(5'h1E, 10);
            hold_len(5'h1E, 60);
            check("hold limit", 32'h1, {31'h0, f ? (n > 8 && n < 40) : (n == 60)});
        end
        // The internal requester is in the high class, so it wins the next grant again.
        wait_gnt(5'h1E, 10);
        hold_len(5'h1E, 60);
        check("reload hold", 32'h1, {31'h0, n > 8 && n < 40});
        $display("test fairness done");
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
